// File: rtl/phy_regs_pkg.sv
// Package for the paged bias and MAC-side control register slice.
// Assumes an APB slave with 32-bit data, one register per aligned word.
package phy_regs_pkg;
    // Printed register numbers are indices; byte address is four times
    localparam logic [4:0] mac_ctrl_index = 5'h10;
    localparam logic [4:0] bias_a_index = 5'h1d;
    localparam logic [4:0] bias_b_index = 5'h1e;
    localparam logic [4:0] page_sel_index = 5'h16;
    localparam logic [4:0] swreset_index = 5'h00;
    localparam logic [4:0] status_index = 5'h01;
    localparam logic [1:0] bias_page = 2'h0;
    localparam logic [1:0] mac_page = 2'h2;
    // Field positions
    localparam int fifo_depth_hi = 15;
    localparam int fifo_depth_lo = 14;
    localparam int fast_off_bit = 9;
    localparam int mid_off_bit = 8;
    localparam int resv_one_bit = 7;
    localparam int rxclk_up_bit = 3;
    localparam int swreset_bit = 15;
    // Writable mask of mac_side_control_one: reserved bit 7 writable, other reserved bits kept at reset value
    localparam logic [15:0] mac_ctrl_mask = 16'hc388;
    localparam logic [15:0] mac_ctrl_reset = 16'h0088;
    localparam logic [15:0] bias_reset = 16'h0000;
    localparam logic [1:0] fifo_depth_reset = 2'h0;
    typedef enum logic [1:0] {
        depth_16_type, depth_24_type, depth_32_type, depth_40_type
    } fifo_depth_type;
endpackage

// File: rtl/strap_follow.sv
// Strap edge follower: holds the current strap level and reports edges.
// Assumes the strap is synchronous to pclk.
`timescale 1ns/1ps
`default_nettype none
module strap_follow (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic strap,
    output logic rise,
    output logic fall
);
    logic armed;
    logic last;
    logic next_armed;
    logic next_last;

    always_comb begin
        next_armed = 1'b1;
        next_last = strap;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            armed <= 1'b0;
            last <= 1'b0;
        end else begin
            armed <= next_armed;
            last <= next_last;
        end
    end

    // No edge reported before the first sample after reset release
    assign rise = armed & strap & ~last;
    assign fall = armed & ~strap & last;
endmodule // strap_follow
`default_nettype wire

// File: rtl/phy_bias_mac_ctrl_regs.sv
// Paged bias tuning and MAC-side control registers with APB access.
// Assumes synchronous straps and a single pclk domain.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - FIFO depth field selects elastic depth
// - Fast clock disable acts after software reset
// - Fast disable follows strap level and edges
// - Mid disable follows its strap similarly
// - Reserved bit 7 reads one, reloads
// - Receive clock bit gates powered-down stop
// - Receive clock change applies at software reset
// - Bias, depth, disables survive software reset
module phy_bias_mac_ctrl_regs (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic fast_clock_off_strap,
    input wire logic mid_clock_off_strap,
    input wire logic phy_powered_down,
    output logic [1:0] fifo_depth,
    output logic fast_clock_off,
    output logic mid_clock_off,
    output logic rx_clock_may_stop,
    output logic [15:0] bias_tune_a,
    output logic [15:0] bias_tune_b
);
    logic [15:0] mac_ctrl;
    logic [15:0] next_mac_ctrl;
    logic [15:0] next_bias_a;
    logic [15:0] next_bias_b;
    logic [1:0] page;
    logic [1:0] next_page;
    logic strap_loaded;
    logic next_strap_loaded;
    logic applied_fast_off;
    logic next_applied_fast_off;
    logic applied_rx_up;
    logic next_applied_rx_up;
    logic [1:0] next_fifo_depth;
    logic next_mid_off;
    logic next_fast_off;
    logic next_rx_may_stop;
    logic [31:0] next_prdata;
    logic [4:0] index;
    logic access;
    logic wr;
    logic hit;
    logic sw_reset;
    logic fast_rise;
    logic fast_fall;
    logic mid_rise;
    logic mid_fall;

    strap_follow fast_edges (
        .pclk(pclk),
        .presetn(presetn),
        .strap(fast_clock_off_strap),
        .rise(fast_rise),
        .fall(fast_fall)
    );

    strap_follow mid_edges (
        .pclk(pclk),
        .presetn(presetn),
        .strap(mid_clock_off_strap),
        .rise(mid_rise),
        .fall(mid_fall)
    );

    assign index = paddr[6:2];
    assign access = psel & penable;
    assign wr = access & pwrite;
    assign pready = 1'b1;

    // Unmapped or wrong-page addresses answer with an error
    always_comb begin
        hit = 1'b0;
        if (paddr[31:7] == 25'h0 && paddr[1:0] == 2'h0) begin
            case (index)
                phy_regs_pkg::page_sel_index: hit = 1'b1;
                phy_regs_pkg::swreset_index: hit = 1'b1;
                phy_regs_pkg::status_index: hit = 1'b1;
                phy_regs_pkg::mac_ctrl_index:
                    hit = (page == phy_regs_pkg::mac_page);
                phy_regs_pkg::bias_a_index,
                phy_regs_pkg::bias_b_index:
                    hit = (page == phy_regs_pkg::bias_page);
                default: hit = 1'b0;
            endcase
        end
    end
    assign pslverr = access & ~hit;
    assign sw_reset = wr & hit & (index == phy_regs_pkg::swreset_index)
        & pwdata[phy_regs_pkg::swreset_bit];

    always_comb begin
        next_page = page;
        next_bias_a = bias_tune_a;
        next_bias_b = bias_tune_b;
        next_mac_ctrl = mac_ctrl;
        next_strap_loaded = 1'b1;
        next_applied_fast_off = applied_fast_off;
        next_applied_rx_up = applied_rx_up;
        if (wr && hit) begin
            case (index)
                phy_regs_pkg::page_sel_index: next_page = pwdata[1:0];
                phy_regs_pkg::bias_a_index: next_bias_a = pwdata[15:0];
                phy_regs_pkg::bias_b_index: next_bias_b = pwdata[15:0];
                phy_regs_pkg::mac_ctrl_index:
                    next_mac_ctrl =
                        (pwdata[15:0] & phy_regs_pkg::mac_ctrl_mask)
                        | (mac_ctrl & ~phy_regs_pkg::mac_ctrl_mask);
                default: next_page = page;
            endcase
        end
        // Straps load after release; a strap edge wins over a write
        if (!strap_loaded) begin
            next_mac_ctrl[phy_regs_pkg::fast_off_bit] =
                fast_clock_off_strap;
            next_mac_ctrl[phy_regs_pkg::mid_off_bit] =
                mid_clock_off_strap;
        end else begin
            if (fast_rise) begin
                next_mac_ctrl[phy_regs_pkg::fast_off_bit] = 1'b1;
            end
            if (fast_fall) begin
                next_mac_ctrl[phy_regs_pkg::fast_off_bit] = 1'b0;
            end
            if (mid_rise) begin
                next_mac_ctrl[phy_regs_pkg::mid_off_bit] = 1'b1;
            end
            if (mid_fall) begin
                next_mac_ctrl[phy_regs_pkg::mid_off_bit] = 1'b0;
            end
        end
        // Disruptive bits only reach the logic on software reset or, for fast disable, the strap load
        if (sw_reset || !strap_loaded) begin
            next_applied_fast_off = !strap_loaded ? fast_clock_off_strap
                : mac_ctrl[phy_regs_pkg::fast_off_bit];
        end
        if (sw_reset) begin
            next_applied_rx_up = mac_ctrl[phy_regs_pkg::rxclk_up_bit];
            next_mac_ctrl[phy_regs_pkg::resv_one_bit] = 1'b1;
            // Bias, depth and clock disables are retained here
        end
    end

    // Read data loads in the setup cycle; refused reads return zero
    always_comb begin
        next_prdata = prdata;
        if (psel && !penable && !pwrite && !hit) begin
            next_prdata = 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            case (index)
                phy_regs_pkg::page_sel_index: next_prdata = {30'h0, page};
                phy_regs_pkg::mac_ctrl_index: next_prdata = {16'h0, mac_ctrl};
                phy_regs_pkg::bias_a_index: next_prdata = {16'h0, bias_tune_a};
                phy_regs_pkg::bias_b_index: next_prdata = {16'h0, bias_tune_b};
                phy_regs_pkg::status_index:
                    next_prdata = {29'h0, applied_fast_off, applied_rx_up,
                        rx_clock_may_stop};
                default: next_prdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            page <= 2'h0;
            bias_tune_a <= phy_regs_pkg::bias_reset;
            bias_tune_b <= phy_regs_pkg::bias_reset;
            mac_ctrl <= phy_regs_pkg::mac_ctrl_reset;
            strap_loaded <= 1'b0;
            applied_fast_off <= 1'b0;
            applied_rx_up <= 1'b1;
            prdata <= 32'h0000_0000;
        end else begin
            page <= next_page;
            bias_tune_a <= next_bias_a;
            bias_tune_b <= next_bias_b;
            mac_ctrl <= next_mac_ctrl;
            strap_loaded <= next_strap_loaded;
            applied_fast_off <= next_applied_fast_off;
            applied_rx_up <= next_applied_rx_up;
            prdata <= next_prdata;
        end
    end

    always_comb begin
        next_fifo_depth = mac_ctrl[phy_regs_pkg::fifo_depth_hi:
            phy_regs_pkg::fifo_depth_lo];
        next_mid_off = mac_ctrl[phy_regs_pkg::mid_off_bit];
        // Only the applied copy drives the clock, never the register bit
        next_fast_off = applied_fast_off;
        // Stop allowed only once a cleared bit has been applied
        next_rx_may_stop = ~applied_rx_up & phy_powered_down;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fifo_depth <= phy_regs_pkg::fifo_depth_reset;
            mid_clock_off <= 1'b0;
            fast_clock_off <= 1'b0;
            rx_clock_may_stop <= 1'b0;
        end else begin
            fifo_depth <= next_fifo_depth;
            mid_clock_off <= next_mid_off;
            fast_clock_off <= next_fast_off;
            rx_clock_may_stop <= next_rx_may_stop;
        end
    end

    // Applied copies move only on a software reset or the strap load
    fast_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        strap_loaded && !sw_reset |=> $stable(applied_fast_off))
        else $error("fast clock disable changed without software reset");
    fast_out_a: assert property (@(posedge pclk) disable iff (!presetn)
        ##1 fast_clock_off == $past(applied_fast_off))
        else $error("fast clock output does not follow applied bit");
    rx_apply_a: assert property (@(posedge pclk) disable iff (!presetn)
        sw_reset |=> applied_rx_up
            == $past(mac_ctrl[phy_regs_pkg::rxclk_up_bit]))
        else $error("receive clock bit not applied on software reset");
    rx_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        !sw_reset |=> $stable(applied_rx_up))
        else $error("receive clock bit applied without software reset");
    rx_stop_a: assert property (@(posedge pclk) disable iff (!presetn)
        applied_rx_up |=> !rx_clock_may_stop)
        else $error("receive clock may stop while held up");
    rx_may_stop_a: assert property (@(posedge pclk) disable iff (!presetn)
        !applied_rx_up && phy_powered_down |=> rx_clock_may_stop)
        else $error("receive clock kept up although allowed to stop");

    // Strap level at load, then strap edges, own the disable bits
    strap_load_a: assert property (@(posedge pclk) disable iff (!presetn)
        !strap_loaded |=> mac_ctrl[phy_regs_pkg::fast_off_bit]
            == $past(fast_clock_off_strap)
            && mac_ctrl[phy_regs_pkg::mid_off_bit]
            == $past(mid_clock_off_strap))
        else $error("clock disables not loaded from straps");
    fast_edge_a: assert property (@(posedge pclk) disable iff (!presetn)
        fast_rise && strap_loaded |=> mac_ctrl[phy_regs_pkg::fast_off_bit])
        else $error("fast strap rise did not set disable");
    fast_fall_a: assert property (@(posedge pclk) disable iff (!presetn)
        fast_fall && strap_loaded |=> !mac_ctrl[phy_regs_pkg::fast_off_bit])
        else $error("fast strap fall did not clear disable");
    mid_edge_a: assert property (@(posedge pclk) disable iff (!presetn)
        mid_fall && strap_loaded |=> !mac_ctrl[phy_regs_pkg::mid_off_bit])
        else $error("mid strap fall did not clear disable");
    mid_rise_a: assert property (@(posedge pclk) disable iff (!presetn)
        mid_rise && strap_loaded |=> mac_ctrl[phy_regs_pkg::mid_off_bit])
        else $error("mid strap rise did not set disable");
    mid_out_a: assert property (@(posedge pclk) disable iff (!presetn)
        ##1 mid_clock_off == $past(mac_ctrl[phy_regs_pkg::mid_off_bit]))
        else $error("mid clock output does not follow disable bit");

    // Software reset keeps tuning state and reloads bit seven
    resv_one_a: assert property (@(posedge pclk) disable iff (!presetn)
        sw_reset |=> mac_ctrl[phy_regs_pkg::resv_one_bit])
        else $error("reserved bit seven not reloaded");
    bias_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
        sw_reset |=> $stable(bias_tune_a) && $stable(bias_tune_b))
        else $error("bias lost on software reset");
    depth_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
        sw_reset |=> $stable(mac_ctrl[
            phy_regs_pkg::fifo_depth_hi:phy_regs_pkg::fifo_depth_lo]))
        else $error("fifo depth lost on software reset");
    off_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
        sw_reset && strap_loaded && !fast_rise && !fast_fall
        |=> $stable(mac_ctrl[phy_regs_pkg::fast_off_bit]))
        else $error("fast clock disable lost on software reset");
    depth_out_a: assert property (@(posedge pclk) disable iff (!presetn)
        ##1 fifo_depth == $past(mac_ctrl[
            phy_regs_pkg::fifo_depth_hi:phy_regs_pkg::fifo_depth_lo]))
        else $error("fifo depth output does not follow field");

    // Refused accesses: wrong page or unmapped address
    page_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
        access && index == phy_regs_pkg::bias_a_index
        && page != phy_regs_pkg::bias_page |-> pslverr)
        else $error("bias register reachable off page");
    page_mac_a: assert property (@(posedge pclk) disable iff (!presetn)
        access && index == phy_regs_pkg::mac_ctrl_index
        && page != phy_regs_pkg::mac_page |-> pslverr)
        else $error("mac control register reachable off page");
    refused_write_a: assert property (@(posedge pclk) disable iff (!presetn)
        wr && pslverr
        |=> $stable(bias_tune_a) && $stable(bias_tune_b) && $stable(page))
        else $error("refused write changed a register");
    refused_read_a: assert property (@(posedge pclk) disable iff (!presetn)
        access && !pwrite && pslverr |-> prdata == 32'h0000_0000)
        else $error("refused read returned data");
endmodule // phy_bias_mac_ctrl_regs
`default_nettype wire

// File: testbench/tb.sv
// Self-checking bench for the paged bias and MAC-side control registers.
// Assumes the APB slave answers with pready and straps are pclk-synchronous.
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] paddr = 32'h0000_0000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic fast_strap = 1'b1;
    logic mid_strap = 1'b0;
    logic powered_down = 1'b1;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [1:0] fifo_depth;
    logic fast_clock_off;
    logic mid_clock_off;
    logic rx_clock_may_stop;
    logic [15:0] bias_tune_a;
    logic [15:0] bias_tune_b;
    int n_fail = 0;
    int n_compared = 0;
    logic [31:0] r;
    logic e;
    always #10 pclk = ~pclk;
    phy_bias_mac_ctrl_regs i_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr),
        .fast_clock_off_strap(fast_strap), .mid_clock_off_strap(mid_strap),
        .phy_powered_down(powered_down), .fifo_depth(fifo_depth),
        .fast_clock_off(fast_clock_off), .mid_clock_off(mid_clock_off),
        .rx_clock_may_stop(rx_clock_may_stop), .bias_tune_a(bias_tune_a),
        .bias_tune_b(bias_tune_b));
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        n_compared++;
        if (g !== x) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, g, x);
        end
    endtask
    // Entered just after a rising edge; leaves one idle cycle behind
    task automatic apb(input logic w, input logic [31:0] a,
        input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic rd(input logic [31:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0000_0000);
        chk(r, x);
        chk({31'h0, e}, 32'h0000_0000);
    endtask
    task automatic bad(input logic [31:0] a);
        apb(1'b0, a, 32'h0000_0000);
        chk(r, 32'h0000_0000);
        chk({31'h0, e}, 32'h0000_0001);
    endtask
    task automatic t_reset;
        chk({30'h0, fifo_depth}, 32'h0000_0000);
        chk({31'h0, fast_clock_off}, 32'h0000_0001);
        chk({31'h0, mid_clock_off}, 32'h0000_0000);
        chk({31'h0, rx_clock_may_stop}, 32'h0000_0000);
        bad(32'h0000_0040);
        rd(32'h0000_0074, 32'h0000_0000);
        rd(32'h0000_0004, 32'h0000_0006);
        apb(1'b1, 32'h0000_0058, 32'h0000_0002);
        rd(32'h0000_0040, 32'h0000_0288);
        bad(32'h0000_0074);
        bad(32'h0000_0008);
        apb(1'b1, 32'h0000_0074, 32'h0000_ffff);
        chk({31'h0, e}, 32'h0000_0001);
        chk({16'h0, bias_tune_a}, 32'h0000_0000);
        $display("test reset done");
    endtask
    task automatic t_depth;
        for (int c = 0; c < 4; c++) begin
            apb(1'b1, 32'h0000_0040, 32'h0000_0288 | (c << 14));
            rd(32'h0000_0040, 32'h0000_0288 | (c << 14));
            chk({30'h0, fifo_depth}, c);
        end
        $display("test depth done");
    endtask
    task automatic t_swreset;
        apb(1'b1, 32'h0000_0040, 32'h0000_c080);
        repeat (2) @(posedge pclk);
        chk({31'h0, fast_clock_off}, 32'h0000_0001);
        chk({31'h0, rx_clock_may_stop}, 32'h0000_0000);
        apb(1'b1, 32'h0000_0058, 32'h0000_0000);
        apb(1'b1, 32'h0000_0074, 32'h0000_0003);
        apb(1'b1, 32'h0000_0078, 32'h0000_0000);
        chk({16'h0, bias_tune_a}, 32'h0000_0003);
        chk({16'h0, bias_tune_b}, 32'h0000_0000);
        apb(1'b1, 32'h0000_0000, 32'h0000_8000);
        repeat (2) @(posedge pclk);
        chk({31'h0, fast_clock_off}, 32'h0000_0000);
        chk({31'h0, rx_clock_may_stop}, 32'h0000_0001);
        chk({30'h0, fifo_depth}, 32'h0000_0003);
        rd(32'h0000_0004, 32'h0000_0001);
        apb(1'b1, 32'h0000_0058, 32'h0000_0000);
        rd(32'h0000_0074, 32'h0000_0003);
        apb(1'b1, 32'h0000_0058, 32'h0000_0002);
        rd(32'h0000_0040, 32'h0000_c080);
        powered_down <= 1'b0;
        repeat (2) @(posedge pclk);
        chk({31'h0, rx_clock_may_stop}, 32'h0000_0000);
        $display("test software reset done");
    endtask
    task automatic t_straps;
        mid_strap <= 1'b1;
        fast_strap <= 1'b0;
        repeat (4) @(posedge pclk);
        chk({31'h0, mid_clock_off}, 32'h0000_0001);
        rd(32'h0000_0040, 32'h0000_c180);
        fast_strap <= 1'b1;
        mid_strap <= 1'b0;
        repeat (4) @(posedge pclk);
        chk({31'h0, mid_clock_off}, 32'h0000_0000);
        chk({31'h0, fast_clock_off}, 32'h0000_0000);
        rd(32'h0000_0040, 32'h0000_c280);
        $display("test straps done");
    endtask
    task automatic t_hw_reset;
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
        chk({16'h0, bias_tune_a}, 32'h0000_0000);
        chk({30'h0, fifo_depth}, 32'h0000_0000);
        chk({31'h0, fast_clock_off}, 32'h0000_0001);
        chk({31'h0, mid_clock_off}, 32'h0000_0000);
        rd(32'h0000_0004, 32'h0000_0006);
        apb(1'b1, 32'h0000_0058, 32'h0000_0002);
        rd(32'h0000_0040, 32'h0000_0288);
        $display("test hardware reset done");
    endtask
    task automatic results;
        $display("compared %0d, failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        // Outputs launched at the second edge are read at the third
        repeat (3) @(posedge pclk);
        t_reset();
        t_depth();
        t_swreset();
        t_straps();
        t_hw_reset();
        results();
    end
    initial begin
        repeat (3000) @(posedge pclk);
        n_fail++;
        results();
    end
endmodule // tb
`default_nettype wire
